/* File: pkg/uart_rx_tx_pkg.sv */
// Constants and types shared by the serial channel pair and its receive buffer.
// Assumes one system clock that also serves as the channel operation clock.
package uart_rx_tx_pkg;

    localparam int CHAR_W = 9;
    localparam int FIFO_DEPTH = 32;
    localparam logic IS_FIRST_PORT = 1'b1;

    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] PAIR_MODE_OFS = 8'h04;
    localparam logic [7:0] CONFIG_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] CLEAR_OFS = 8'h14;
    localparam logic [7:0] START_OFS = 8'h18;

    localparam int MODE_SRC_BIT = 0;
    localparam int CFG_RXE_BIT = 0;
    localparam int CFG_TXE_BIT = 1;
    localparam int CFG_PAR_LSB = 2;
    localparam int CFG_DIR_BIT = 4;
    localparam int CFG_LEN_LSB = 5;
    localparam int DATA_DIV_LSB = 9;
    localparam int STS_BFF_BIT = 0;
    localparam int STS_TXBUSY_BIT = 1;
    localparam int STS_RXRDY_BIT = 2;
    localparam int STS_FEF_BIT = 3;
    localparam int STS_PEF_BIT = 4;
    localparam int STS_OVF_BIT = 5;
    localparam int START_GO_BIT = 0;
    localparam int START_HALT_BIT = 1;

    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] CONFIG_RST = 16'h0060;
    localparam logic [6:0] DIV_RST = 7'h0c;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [1:0] LEN_9 = 2'h1;
    localparam logic [1:0] LEN_7 = 2'h2;

    typedef enum logic [2:0] {F_IDLE, F_START, F_DATA, F_PARITY, F_STOP} frame_state_t;

endpackage

/* File: pkg/stream_if.sv */
// Valid/ready stream carrier between the channel and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: design/stream_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset on the same clock as both ends.
`timescale 1ns/1ns
module stream_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Streams
    stream_if.snk inPort,
    stream_if.src outPort
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic doPush;
    logic doPop;

    assign inPort.ready = count != CW'(DEPTH);
    assign outPort.valid = count != '0;
    assign outPort.data = mem[rdPtr];
    assign doPush = inPort.valid && inPort.ready;
    assign doPop = outPort.valid && outPort.ready;

    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr] <= inPort.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: design/uart_channel_rx_tx.sv */
// Asynchronous serial channel pair: buffered transmitter and odd-channel receiver.
// Assumes a classic Wishbone master on clk_sys and the operation clock equal to clk_sys.
//
// Overview of operation
// RL1 - A data write while the buffer-full flag is set replaces the pending transmit word.
// RL2 - Software changes the interrupt source select before the last bit of the last word starts.
// RL3 - Reception is done by the odd channel of the pair that forms one serial port.
// RL4 - Software programs the mode registers of both the odd and the paired even channel.
// RL5 - The receiver raises only a transfer-end interrupt, never a buffer-empty one.
// RL6 - Framing, parity and overrun errors each set a flag and raise a separate error interrupt.
// RL7 - Character length is 7, 8 or 9 bits, with 9 bits only on the first port.
// RL8 - In 9-bit mode the data register returns the character in its low nine bits.
// RL9 - Software sets the baud divider to 2 or more, giving rates down from the clock over six.
// RL10 - Parity is none, an unchecked zero bit, even or odd.
// RL11 - Software waits four clock cycles after receive enable before starting the channel.
// RL12 - In receive mode the serial output level and output enable are left unused.
// RL13 - After the clock supply is cut during a stop, software reinitializes instead of resuming.
// RL14 - The bit rate is the operation clock over the divider plus one, over two.
// RL15 - One stop bit is checked and a framing error reported when it is not high.
// RL16 - Characters are assembled most-significant or least-significant bit first.
// RL17 - The line is non-inverted with a high idle level and a frame starts on a falling edge.
`timescale 1ns/1ns
module uart_channel_rx_tx
    import uart_rx_tx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Serial pins
    input wire logic serialInPin,
    output logic serialOut,
    output logic serialOutEn,
    // Event pulses
    output logic receiveEndIrq,
    output logic receiveErrorIrq,
    output logic transmitIrq
);
    logic [15:0] channelModeReg;
    logic [15:0] pairModeReg;
    logic [15:0] commConfigReg;
    logic [6:0] divider;
    logic [CHAR_W-1:0] txBuf;
    logic bufferFullFlag;
    logic chanEnabled;
    logic framingErrorFlag;
    logic parityErrorFlag;
    logic overrunErrorFlag;
    logic rxSync0;
    logic rxSync1;
    logic rxPrev;
    logic busHit;
    logic busDone;
    logic [31:0] wmask;
    logic [31:0] readMux;
    logic [3:0] charLen;
    logic [CHAR_W-1:0] lenMask;
    logic [1:0] parMode;
    logic lsbFirst;
    logic [8:0] bitLen;
    logic [8:0] halfLen;
    frame_state_t rxState;
    logic [8:0] rxTimer;
    logic [3:0] rxIdx;
    logic [CHAR_W-1:0] rxChar;
    logic rxParBit;
    logic rxTick;
    logic rxEdge;
    frame_state_t txState;
    logic [8:0] txTimer;
    logic [3:0] txIdx;
    logic [CHAR_W-1:0] txShift;
    logic txTick;
    logic txLoad;
    logic dataWrite;
    logic next_fe;
    logic next_pe;

    stream_if #(.W(CHAR_W)) rxPush();
    stream_if #(.W(CHAR_W)) rxPop();

    stream_fifo #(.W(CHAR_W), .DEPTH(FIFO_DEPTH)) rxFifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .inPort(rxPush),
        .outPort(rxPop)
    );

    function automatic logic [3:0] bitPos(input logic [3:0] idx, input logic [3:0] len, input logic lsb);
        bitPos = lsb ? idx : 4'(len - idx - 4'h1);
    endfunction

    // Byte lanes of the bus write.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{sel_i[i]}};
        end
    end

    assign busHit = cyc_i && stb_i;
    assign busDone = busHit && ack_o;
    assign dataWrite = busDone && we_i && adr_i == DATA_OFS;

    // RL7 length select, nine bits on first port.
    always_comb begin
        unique case (commConfigReg[CFG_LEN_LSB +: 2])
            LEN_9: charLen = IS_FIRST_PORT ? 4'h9 : 4'h8;
            LEN_7: charLen = 4'h7;
            default: charLen = 4'h8;
        endcase
        lenMask = CHAR_W'((10'h1 << charLen) - 10'h1);
    end

    assign parMode = commConfigReg[CFG_PAR_LSB +: 2];
    assign lsbFirst = commConfigReg[CFG_DIR_BIT];
    // RL14 half and whole bit period.
    assign halfLen = {1'b0, 8'(divider) + 8'h1};
    assign bitLen = {halfLen[7:0], 1'b0};

    // Wishbone acknowledge, one cycle per access.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= busHit && !ack_o;
        end
    end

    always_comb begin
        readMux = 32'h0;
        unique case (adr_i)
            MODE_OFS: readMux = {16'h0, channelModeReg};
            PAIR_MODE_OFS: readMux = {16'h0, pairModeReg};
            CONFIG_OFS: readMux = {16'h0, commConfigReg};
            // RL8 nine-bit character in low bits.
            DATA_OFS: readMux = {16'h0, divider, rxPop.data};
            STATUS_OFS: begin
                readMux[STS_BFF_BIT] = bufferFullFlag;
                readMux[STS_TXBUSY_BIT] = txState != F_IDLE;
                readMux[STS_RXRDY_BIT] = rxPop.valid;
                readMux[STS_FEF_BIT] = framingErrorFlag;
                readMux[STS_PEF_BIT] = parityErrorFlag;
                readMux[STS_OVF_BIT] = overrunErrorFlag;
            end
            START_OFS: readMux[START_GO_BIT] = chanEnabled;
            default: readMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dat_o <= 32'h0;
        end else if (busHit && !ack_o && !we_i) begin
            dat_o <= readMux;
        end
    end

    // Reading the data register takes the oldest character.
    assign rxPop.ready = busDone && !we_i && adr_i == DATA_OFS;

    // RL4 both mode registers are software owned.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            channelModeReg <= MODE_RST;
            pairModeReg <= MODE_RST;
            commConfigReg <= CONFIG_RST;
            divider <= DIV_RST;
        end else if (busDone && we_i) begin
            unique case (adr_i)
                MODE_OFS: channelModeReg <= (channelModeReg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                PAIR_MODE_OFS: pairModeReg <= (pairModeReg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                CONFIG_OFS: commConfigReg <= (commConfigReg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                DATA_OFS: begin
                    if (sel_i[1]) begin
                        divider <= dat_i[DATA_DIV_LSB +: 7];
                    end
                end
                default: ;
            endcase
        end
    end

    // Channel start and stop triggers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chanEnabled <= 1'b0;
        end else if (busDone && we_i && adr_i == START_OFS && sel_i[0]) begin
            if (dat_i[START_HALT_BIT]) begin
                chanEnabled <= 1'b0;
            end else if (dat_i[START_GO_BIT]) begin
                chanEnabled <= 1'b1;
            end
        end
    end

    // RL1 overwrite pending word, write beats load.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txBuf <= '0;
            bufferFullFlag <= 1'b0;
        end else if (dataWrite && sel_i[0]) begin
            txBuf <= {sel_i[1] ? dat_i[8] : txBuf[8], dat_i[7:0]};
            bufferFullFlag <= 1'b1;
        end else if (txLoad) begin
            bufferFullFlag <= 1'b0;
        end
    end

    // RL17 line synchroniser and edge detect.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxSync0 <= 1'b1;
            rxSync1 <= 1'b1;
            rxPrev <= 1'b1;
        end else begin
            rxSync0 <= serialInPin;
            rxSync1 <= rxSync0;
            rxPrev <= rxSync1;
        end
    end

    assign rxEdge = rxPrev && !rxSync1;
    assign rxTick = rxTimer == 9'h0;

    // RL3 receiver of the odd channel.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxState <= F_IDLE;
            rxTimer <= 9'h0;
            rxIdx <= 4'h0;
            rxChar <= '0;
            rxParBit <= 1'b0;
        end else if (!chanEnabled || !commConfigReg[CFG_RXE_BIT]) begin
            rxState <= F_IDLE;
        end else begin
            rxTimer <= rxTick ? bitLen - 9'h1 : rxTimer - 9'h1;
            unique case (rxState)
                F_IDLE: begin
                    if (rxEdge) begin
                        rxState <= F_START;
                        rxTimer <= halfLen - 9'h1;
                    end
                end
                F_START: begin
                    if (rxTick) begin
                        rxIdx <= 4'h0;
                        rxChar <= '0;
                        rxState <= rxSync1 ? F_IDLE : F_DATA;
                    end
                end
                F_DATA: begin
                    if (rxTick) begin
                        // RL16 place bit by order.
                        rxChar[bitPos(rxIdx, charLen, lsbFirst)] <= rxSync1;
                        rxIdx <= rxIdx + 4'h1;
                        if (rxIdx == charLen - 4'h1) begin
                            rxState <= parMode == PAR_NONE ? F_STOP : F_PARITY;
                        end
                    end
                end
                F_PARITY: begin
                    if (rxTick) begin
                        rxParBit <= rxSync1;
                        rxState <= F_STOP;
                    end
                end
                F_STOP: begin
                    if (rxTick) begin
                        rxState <= F_IDLE;
                    end
                end
            endcase
        end
    end

    // RL15 single stop bit must be high.
    assign next_fe = !rxSync1;
    // RL10 only even and odd are checked.
    always_comb begin
        unique case (parMode)
            PAR_EVEN: next_pe = (^(rxChar & lenMask)) != rxParBit;
            PAR_ODD: next_pe = (^(rxChar & lenMask)) == rxParBit;
            default: next_pe = 1'b0;
        endcase
    end

    assign rxPush.valid = rxState == F_STOP && rxTick && chanEnabled && commConfigReg[CFG_RXE_BIT];
    assign rxPush.data = rxChar & lenMask;

    // RL6 sticky error flags, set beats clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            framingErrorFlag <= 1'b0;
            parityErrorFlag <= 1'b0;
            overrunErrorFlag <= 1'b0;
        end else begin
            if (busDone && we_i && adr_i == CLEAR_OFS && sel_i[0]) begin
                framingErrorFlag <= framingErrorFlag & ~dat_i[STS_FEF_BIT];
                parityErrorFlag <= parityErrorFlag & ~dat_i[STS_PEF_BIT];
                overrunErrorFlag <= overrunErrorFlag & ~dat_i[STS_OVF_BIT];
            end
            if (rxPush.valid) begin
                if (next_fe) begin
                    framingErrorFlag <= 1'b1;
                end
                if (next_pe) begin
                    parityErrorFlag <= 1'b1;
                end
                if (!rxPush.ready) begin
                    overrunErrorFlag <= 1'b1;
                end
            end
        end
    end

    // RL5 receive end only, RL6 separate error pulse.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            receiveEndIrq <= 1'b0;
            receiveErrorIrq <= 1'b0;
        end else begin
            receiveEndIrq <= rxPush.valid && !(next_fe || next_pe || !rxPush.ready);
            receiveErrorIrq <= rxPush.valid && (next_fe || next_pe || !rxPush.ready);
        end
    end

    assign txTick = txTimer == 9'h0;
    assign txLoad = txState == F_IDLE && chanEnabled && commConfigReg[CFG_TXE_BIT] && bufferFullFlag;

    // Transmitter of the even channel.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txState <= F_IDLE;
            txTimer <= 9'h0;
            txIdx <= 4'h0;
            txShift <= '0;
            serialOut <= 1'b1;
        end else if (!chanEnabled) begin
            txState <= F_IDLE;
            serialOut <= 1'b1;
        end else begin
            txTimer <= txTick ? bitLen - 9'h1 : txTimer - 9'h1;
            unique case (txState)
                F_IDLE: begin
                    if (txLoad) begin
                        txShift <= txBuf & lenMask;
                        txState <= F_START;
                        txTimer <= bitLen - 9'h1;
                        serialOut <= 1'b0;
                    end
                end
                F_START: begin
                    if (txTick) begin
                        txIdx <= 4'h1;
                        txState <= F_DATA;
                        serialOut <= txShift[bitPos(4'h0, charLen, lsbFirst)];
                    end
                end
                F_DATA: begin
                    if (txTick) begin
                        txIdx <= txIdx + 4'h1;
                        if (txIdx == charLen) begin
                            txState <= parMode == PAR_NONE ? F_STOP : F_PARITY;
                            serialOut <= parMode == PAR_NONE ? 1'b1 :
                                (parMode == PAR_ZERO ? 1'b0 : (^txShift) ^ (parMode == PAR_ODD));
                        end else begin
                            serialOut <= txShift[bitPos(txIdx, charLen, lsbFirst)];
                        end
                    end
                end
                F_PARITY: begin
                    if (txTick) begin
                        txState <= F_STOP;
                        serialOut <= 1'b1;
                    end
                end
                F_STOP: begin
                    if (txTick) begin
                        txState <= F_IDLE;
                    end
                end
            endcase
        end
    end

    // RL12 output unused while only receiving.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= chanEnabled && commConfigReg[CFG_TXE_BIT];
        end
    end

    // RL2 source select sampled at each event.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            transmitIrq <= 1'b0;
        end else if (channelModeReg[MODE_SRC_BIT]) begin
            transmitIrq <= txLoad;
        end else begin
            transmitIrq <= txState == F_STOP && txTick && chanEnabled;
        end
    end
endmodule

/* File: tb/uart_channel_rx_tx_properties.sv */
// Port-level checks on the serial channel pair.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/1ns
module uart_channel_rx_tx_properties
    import uart_rx_tx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Serial and events
    input wire logic serialInPin,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic receiveEndIrq,
    input wire logic receiveErrorIrq,
    input wire logic transmitIrq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_ack_answer:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
    chk_ack_single:
        assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_upper_zero:
        assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000) else $error("upper read bits set");
    chk_unmapped_zero:
        assert property (ack_o && !we_i && adr_i > START_OFS |-> dat_o == 32'h0) else $error("unmapped read not 0");
    chk_irq_exclusive:
        assert property (!(receiveEndIrq && receiveErrorIrq)) else $error("end and error pulse together");
    chk_end_pulse:
        assert property (receiveEndIrq |=> !receiveEndIrq) else $error("end pulse too long");
    chk_err_pulse:
        assert property (receiveErrorIrq |=> !receiveErrorIrq) else $error("error pulse too long");
    chk_stop_high:
        assert property (receiveEndIrq |-> $past(serialInPin, 3)) else $error("end pulse without stop level");
    chk_tx_enabled:
        assert property ($fell(serialOut) |-> serialOutEn) else $error("line driven while disabled");
    cover property (receiveEndIrq);
    cover property (receiveErrorIrq);
    cover property (transmitIrq);
endmodule

bind uart_channel_rx_tx uart_channel_rx_tx_properties i_chk(.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .serialInPin(serialInPin), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .receiveEndIrq(receiveEndIrq), .receiveErrorIrq(receiveErrorIrq), .transmitIrq(transmitIrq));

/* File: tb/serial_sender.sv */
// Far device that sends start-stop frames on the receive line.
// Assumes the shared clock; one bit lasts 2*(DIV+1) clocks.
`timescale 1ns/1ns
module serial_sender
    import uart_rx_tx_pkg::*;
#(
    parameter int DIV = 2
) (
    // Clock
    input wire logic clk_sys,
    // Serial line
    output logic line
);
    initial line = 1'b1;
    task automatic putBit(input logic b);
        @(posedge clk_sys);
        line <= b;
        repeat (2 * (DIV + 1) - 1) @(posedge clk_sys);
    endtask
    task automatic sendChar(input logic [8:0] ch, input int nBits, input logic [1:0] par, input logic lsb,
        input logic badPar, input logic badStop);
        logic p;
        p = (^ch) ^ (par == PAR_ODD);
        if (par == PAR_ZERO)
            p = 1'b0;
        putBit(1'b0);
        for (int i = 0; i < nBits; i++)
            putBit(ch[lsb ? i : nBits - 1 - i]);
        if (par != PAR_NONE)
            putBit(p ^ badPar);
        putBit(~badStop);
        putBit(1'b1);
    endtask
endmodule

/* File: tb/uart_channel_rx_tx_tb.sv */
// Self-checking bench for the serial channel pair.
// Assumes the design package and a sender model on the receive line.
`timescale 1ns/1ns
module uart_channel_rx_tx_tb;
    import uart_rx_tx_pkg::*;
    localparam int DIV = 2;
    localparam int BIT = 2 * (DIV + 1);
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] datOut;
    logic ack, rxLine, txLine, txEn, endIrq, errIrq, txIrq;
    int nErrors = 0;
    int totalChecks = 0;
    int nEnd = 0;
    int nErr = 0;
    int nTx = 0;
    logic [15:0] cfgs [4] = '{16'h0013, 16'h0049, 16'h003f, 16'h0007};
    logic [8:0] chs [4] = '{9'h0a5, 9'h05a, 9'h1c3, 9'h03c};
    int nbs [4] = '{8, 7, 9, 8};

    uart_channel_rx_tx i_dut(.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(datOut), .ack_o(ack), .serialInPin(rxLine), .serialOut(txLine),
        .serialOutEn(txEn), .receiveEndIrq(endIrq), .receiveErrorIrq(errIrq), .transmitIrq(txIrq));
    serial_sender #(.DIV(DIV)) i_peer(.clk_sys(clk_sys), .line(rxLine));

    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (endIrq === 1'b1)
            nEnd <= nEnd + 1;
        if (errIrq === 1'b1)
            nErr <= nErr + 1;
        if (txIrq === 1'b1)
            nTx <= nTx + 1;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            nErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, 4'hf, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        check(rdat, e);
    endtask
    task automatic setup(input logic [15:0] cfg);
        wr(START_OFS, 32'h2);
        wr(CONFIG_OFS, {16'h0, cfg});
        repeat (4) @(posedge clk_sys);
        wr(START_OFS, 32'h1);
    endtask
    task automatic txFrame(output logic [7:0] c);
        @(negedge txLine);
        repeat (DIV + 1) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_sys);
            c[i] = txLine;
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        nErrors++;
        conclude();
    end

    initial begin
        logic [7:0] c1, c2;
        int e, f;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(MODE_OFS, 32'h0);
        rd(CONFIG_OFS, 32'h60);
        rd(8'h1c, 32'h0);
        wb(1'b1, DATA_OFS, 4'h2, 32'h0400);
        wb(1'b0, DATA_OFS, 4'hf, 32'h0);
        check(rdat & 32'hfe00, 32'h0400);
        wr(PAIR_MODE_OFS, 32'h0);
        $display("test registers done");
        setup(16'h0013);
        e = nTx;
        wr(MODE_OFS, 32'h1);
        fork
            begin
                txFrame(c1);
                txFrame(c2);
            end
            begin
                wr(DATA_OFS, 32'h0411);
                wr(DATA_OFS, 32'h0422);
                rd(STATUS_OFS, 32'h3);
                wr(DATA_OFS, 32'h0433);
                wr(MODE_OFS, 32'h0);
            end
        join
        check(c1, 8'h11);
        check(c2, 8'h33);
        repeat (2 * BIT) @(posedge clk_sys);
        check(nTx - e, 3);
        $display("test transmit done");
        for (int i = 0; i < 4; i++) begin
            setup(cfgs[i]);
            e = nEnd;
            i_peer.sendChar(chs[i], nbs[i], cfgs[i][3:2], cfgs[i][4], 1'b0, 1'b0);
            check(txEn, cfgs[i][1]);
            rd(STATUS_OFS, 32'h4);
            rd(DATA_OFS, 32'h0400 | chs[i]);
            check(nEnd - e, 1);
        end
        $display("test modes done");
        setup(16'h001b);
        e = nErr;
        f = nEnd;
        i_peer.sendChar(9'h055, 8, PAR_EVEN, 1'b1, 1'b1, 1'b0);
        rd(STATUS_OFS, 32'h14);
        rd(DATA_OFS, 32'h0455);
        i_peer.sendChar(9'h033, 8, PAR_EVEN, 1'b1, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h1c);
        rd(DATA_OFS, 32'h0433);
        check(nErr - e, 2);
        check(nEnd - f, 0);
        wr(CLEAR_OFS, 32'h38);
        rd(STATUS_OFS, 32'h0);
        $display("test errors done");
        e = nErr;
        for (int i = 0; i < 33; i++)
            i_peer.sendChar(i[8:0] & 9'h0ff, 8, PAR_EVEN, 1'b1, 1'b0, 1'b0);
        rd(STATUS_OFS, 32'h24);
        check(nErr - e, 1);
        for (int i = 0; i < 32; i++)
            rd(DATA_OFS, 32'h0400 | i);
        wr(CLEAR_OFS, 32'h38);
        rd(STATUS_OFS, 32'h0);
        $display("test overrun done");
        conclude();
    end
endmodule
